// ---- apf_core.sv ----
// Behaviour
// - pulses alternate between the two outputs on successive oscillator cycles
// - each cycle only the selected output may drive; the other stays off
// - both outputs held low while the clock pulse is asserted
// - falling edge of the clock pulse starts the selected output's pulse
// - pwm compare, current limit or overcurrent ends the pulse, first wins
// - normally the ramp crossing the control level ends the pulse
// - pwm compare ignored for the blanking interval after pulse start
// - blanking length is half of resistance in parallel with internal 10k, times capacitance
// - current limit also blanked; after blanking it ends the pulse
// - overcurrent is never blanked and acts at any time
// - overcurrent sets the fault latch and forces both outputs low
// - soft-start starts discharged; error amp output held low while low
// - error amp output follows soft-start as it charges
// - after fault, soft-start discharges at the restart rate
// - no pulses until discharged and no overcurrent; then clear fault, restart
// - fault during soft-start: outputs stop, soft-start first charges full
// - undervoltage lockout holds outputs low until both supplies valid
// - clock/blanking pin is output only and never accepts sync
`timescale 1ns/1ps
module apf_core
	import apf_pkg::*;
#(
	parameter int unsigned OSC_PERIOD = OSC_PERIOD_CYC,
	parameter int unsigned OSC_DISCH = OSC_DISCH_CYC,
	parameter int unsigned BLANK_CYC = BLANK_DEF_CYC,
	parameter int unsigned SS_FULL = SS_FULL_CNT,
	parameter int unsigned SS_STEP = SS_DISCH_STEP
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// comparator flags, asynchronous
	input wire logic pwm_cmp_i,
	input wire logic current_sense_input_lim_i,
	input wire logic current_sense_input_ovc_i,
	// supply monitors, asynchronous
	input wire logic vcc_ok_i,
	input wire logic vref_ok_i,
	// gate drive outputs
	output logic out_a_o,
	output logic out_b_o,
	// clock output, no input path exists
	output logic clock_out_blank_pin_o,
	// soft-start and status
	output logic [15:0] ss_level_o,
	output logic ea_hold_low_o,
	output logic fault_o,
	output logic undervoltage_lockout_o,
	output logic blanking_o
);
	// ==========================================================
	// input synchronisation
	logic [SYNC_BITS-1:0] flags_s;
	apf_sync #(
		.W(SYNC_BITS)
	) u_sync (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.ce_i(ce_i),
		.async_i({vref_ok_i, vcc_ok_i, current_sense_input_ovc_i, current_sense_input_lim_i, pwm_cmp_i}),
		.sync_o(flags_s)
	);

	logic pwm_s;
	logic lim_s;
	logic ovc_s;
	logic supply_ok;
	assign pwm_s = flags_s[SYNC_PWM];
	assign lim_s = flags_s[SYNC_LIM];
	assign ovc_s = flags_s[SYNC_OVC];
	assign supply_ok = flags_s[SYNC_VCC] & flags_s[SYNC_VREF];

	// ==========================================================
	// state
	typedef struct packed {
		logic [15:0] osc_cnt;
		logic clk_pulse;
		logic phase_b;
		logic pulse_on;
		logic [15:0] blank_cnt;
		logic fault;
		logic [15:0] ss_lvl;
		apf_ss_t ss_st;
		logic out_a;
		logic out_b;
	} apf_state_t;

	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [15:0] PERIOD_LAST = 16'(OSC_PERIOD - 1);
	localparam logic [15:0] DISCH_LEN = 16'(OSC_DISCH);
	localparam logic [15:0] BLANK_LEN = 16'(BLANK_CYC);
	localparam logic [15:0] SS_TOP = 16'(SS_FULL);
	localparam logic [15:0] SS_DEC = 16'(SS_STEP);

	apf_state_t st_r;
	apf_state_t st_nxt;

	logic clk_fall;
	logic blank_done;
	logic end_pulse;
	logic may_pulse;

	always_comb begin
		st_nxt = st_r;
		clk_fall = 1'b0;
		blank_done = 1'b0;
		end_pulse = 1'b0;
		may_pulse = 1'b0;

		// ==========================================================
		// oscillator: discharge slice at the start of each period
		if (st_r.osc_cnt >= PERIOD_LAST) begin
			st_nxt.osc_cnt = CNT_ZERO;
		end else begin
			st_nxt.osc_cnt = st_r.osc_cnt + CNT_ONE;
		end
		st_nxt.clk_pulse = (st_nxt.osc_cnt < DISCH_LEN);
		clk_fall = st_r.clk_pulse & ~st_nxt.clk_pulse;

		// ==========================================================
		// soft-start and fault latch
		if (ovc_s) begin
			st_nxt.fault = 1'b1;
		end
		case (st_r.ss_st)
			APF_SS_CHG: begin
				if (st_r.ss_lvl >= SS_TOP) begin
					st_nxt.ss_st = APF_SS_FULL;
				end else begin
					st_nxt.ss_lvl = st_r.ss_lvl + CNT_ONE;
				end
			end
			APF_SS_FULL: begin
				if (st_r.fault) begin
					st_nxt.ss_st = APF_SS_DIS;
				end
			end
			APF_SS_DIS: begin
				if (st_r.ss_lvl > SS_DEC) begin
					st_nxt.ss_lvl = st_r.ss_lvl - SS_DEC;
				end else begin
					st_nxt.ss_lvl = CNT_ZERO;
					// overcurrent still present holds the latch and the restart
					if (!ovc_s) begin
						st_nxt.fault = 1'b0;
						st_nxt.ss_st = APF_SS_CHG;
					end
				end
			end
			default: begin
				st_nxt.ss_st = APF_SS_CHG;
				st_nxt.ss_lvl = CNT_ZERO;
			end
		endcase

		// ==========================================================
		// pulse generation
		may_pulse = supply_ok & ~st_nxt.fault & (st_r.ss_lvl != CNT_ZERO);
		if (clk_fall) begin
			st_nxt.phase_b = ~st_r.phase_b;
			st_nxt.pulse_on = may_pulse;
			st_nxt.blank_cnt = BLANK_LEN;
		end else if (st_r.pulse_on) begin
			if (st_r.blank_cnt != CNT_ZERO) begin
				st_nxt.blank_cnt = st_r.blank_cnt - CNT_ONE;
			end
			blank_done = (st_r.blank_cnt == CNT_ZERO);
			// overcurrent bypasses blanking; compare and limit wait for it
			end_pulse = ovc_s | (blank_done & (pwm_s | lim_s));
			if (end_pulse || st_nxt.clk_pulse || !may_pulse) begin
				st_nxt.pulse_on = 1'b0;
			end
		end

		// only the selected leg follows the pulse
		st_nxt.out_a = st_nxt.pulse_on & ~st_nxt.phase_b & ~st_nxt.clk_pulse;
		st_nxt.out_b = st_nxt.pulse_on & st_nxt.phase_b & ~st_nxt.clk_pulse;

		// ==========================================================
		// lockout: outputs low, soft-start returns to empty
		if (!supply_ok) begin
			st_nxt.pulse_on = 1'b0;
			st_nxt.out_a = 1'b0;
			st_nxt.out_b = 1'b0;
			st_nxt.fault = 1'b0;
			st_nxt.ss_lvl = CNT_ZERO;
			st_nxt.ss_st = APF_SS_CHG;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_r.osc_cnt <= CNT_ZERO;
			st_r.clk_pulse <= 1'b1;
			st_r.phase_b <= 1'b1;
			st_r.pulse_on <= 1'b0;
			st_r.blank_cnt <= CNT_ZERO;
			st_r.fault <= 1'b0;
			st_r.ss_lvl <= CNT_ZERO;
			st_r.ss_st <= APF_SS_CHG;
			st_r.out_a <= 1'b0;
			st_r.out_b <= 1'b0;
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// outputs
	assign out_a_o = st_r.out_a;
	assign out_b_o = st_r.out_b;
	assign clock_out_blank_pin_o = st_r.clk_pulse;
	assign ss_level_o = st_r.ss_lvl;
	assign ea_hold_low_o = (st_r.ss_lvl == CNT_ZERO);
	assign fault_o = st_r.fault;
	assign undervoltage_lockout_o = ~supply_ok;
	assign blanking_o = st_r.pulse_on & (st_r.blank_cnt != CNT_ZERO);
endmodule : apf_core

// ---- apf_sync.sv ----
package apf_pkg;
	// ==========================================================
	// clock and timing sources
	localparam int unsigned CLK_PERIOD_PS = 20000;
	localparam int unsigned OSC_FREQ_KHZ = 500;
	localparam int unsigned CLK_FREQ_KHZ = 50000;
	localparam int unsigned OSC_PERIOD_CYC = CLK_FREQ_KHZ / OSC_FREQ_KHZ;
	localparam int unsigned OSC_DISCH_NS = 200;
	localparam int unsigned OSC_DISCH_CYC = (OSC_DISCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// ==========================================================
	// blanking: half of (r parallel internal 10k) times c, ohm*pF = ps
	localparam int unsigned BLANK_R_INT_OHM = 10000;
	localparam int unsigned BLANK_R_EXT_OHM = 2000;
	localparam int unsigned BLANK_C_PF = 470;
	localparam int unsigned BLANK_REQ_OHM = (BLANK_R_EXT_OHM * BLANK_R_INT_OHM) / (BLANK_R_EXT_OHM + BLANK_R_INT_OHM);
	localparam int unsigned BLANK_PS = (BLANK_REQ_OHM * BLANK_C_PF) / 2;
	localparam int unsigned BLANK_DEF_CYC = (BLANK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// ==========================================================
	// soft-start model
	localparam int unsigned SS_FULL_CNT = 2000;
	localparam int unsigned SS_DISCH_STEP = 1;
	localparam int unsigned SYNC_BITS = 5;
	localparam int unsigned SYNC_PWM = 0;
	localparam int unsigned SYNC_LIM = 1;
	localparam int unsigned SYNC_OVC = 2;
	localparam int unsigned SYNC_VCC = 3;
	localparam int unsigned SYNC_VREF = 4;
	typedef enum logic [2:0] {
		APF_SS_CHG = 3'h1,
		APF_SS_FULL = 3'h2,
		APF_SS_DIS = 3'h4
	} apf_ss_t;
endpackage : apf_pkg

`timescale 1ns/1ps
module apf_sync #(
	parameter int unsigned W = 1
) (
	// clock
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// data
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge clk_i) begin
				if (srst_i) begin
					meta_r[g] <= 1'b0;
					sync_r[g] <= 1'b0;
				end else if (ce_i) begin
					meta_r[g] <= async_i[g];
					sync_r[g] <= meta_r[g];
				end
			end
		end
	endgenerate
	assign sync_o = sync_r;
endmodule : apf_sync

// ---- apf_chk.sv ----
`timescale 1ns/1ps
module apf_chk
	import apf_pkg::*;
#(
	parameter int unsigned BLANK_CYC = BLANK_DEF_CYC,
	parameter int unsigned SS_FULL = SS_FULL_CNT,
	parameter int unsigned SS_STEP = SS_DISCH_STEP
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// watched ports
	input wire logic current_sense_input_ovc_i,
	input wire logic out_a_o,
	input wire logic out_b_o,
	input wire logic clock_out_blank_pin_o,
	input wire logic [15:0] ss_level_o,
	input wire logic ea_hold_low_o,
	input wire logic fault_o,
	input wire logic undervoltage_lockout_o,
	input wire logic blanking_o
);
	// ====
	// helpers
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	logic ph_r;
	logic [7:0] blk_r;
	wire on_w = out_a_o | out_b_o;
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ph_r <= 1'b0;
			blk_r <= 8'h00;
		end else begin
			// phase follows every clock pulse fall, pulse or not
			ph_r <= ph_r ^ $fell(clock_out_blank_pin_o);
			blk_r <= blanking_o ? blk_r + 8'h01 : 8'h00;
		end
	end
	// ====
	// properties
	out_excl_a: assert property (!(out_a_o && out_b_o)) else $error("both outputs high");
	clk_blank_a: assert property (clock_out_blank_pin_o |-> !on_w) else $error("output during clock");
	alt_a_a: assert property ($rose(out_a_o) |-> $fell(clock_out_blank_pin_o) && !ph_r)
		else $error("bad start of a");
	alt_b_a: assert property ($rose(out_b_o) |-> $fell(clock_out_blank_pin_o) && ph_r)
		else $error("bad start of b");
	blank_len_a: assert property ($fell(blanking_o) && on_w |-> blk_r == BLANK_CYC)
		else $error("blank length");
	// blanking still high on the edge before the fall means the pulse was cut inside the window
	blank_end_a: assert property ($fell(on_w) && $past(blanking_o) |-> fault_o || $past(undervoltage_lockout_o))
		else $error("pulse cut in blanking");
	ovc_fault_a: assert property ($rose(current_sense_input_ovc_i) && !undervoltage_lockout_o |-> ##[1:4] fault_o && !on_w)
		else $error("overcurrent missed");
	fault_low_a: assert property (fault_o |-> !on_w) else $error("pulse in fault");
	lockout_low_a: assert property (undervoltage_lockout_o |=> !on_w && !fault_o && ss_level_o == 16'h0000)
		else $error("lockout leak");
	ea_hold_a: assert property (ea_hold_low_o == (ss_level_o == 16'h0000)) else $error("hold low");
	ss_dis_a: assert property (fault_o && $past(fault_o) && ss_level_o < $past(ss_level_o) |->
		ss_level_o == $past(ss_level_o) - SS_STEP && ($past(ss_level_o) == SS_FULL || $past(ss_level_o) < $past(ss_level_o, 2)))
		else $error("soft-start discharge");
	// latch clears on the edge that empties soft-start, or later if overcurrent persists, so look at the level it lands on
	fault_clr_a: assert property ($fell(fault_o) && !$past(undervoltage_lockout_o) |-> ss_level_o == 16'h0000)
		else $error("early restart");
	cov_b_c: cover property ($rose(out_b_o));
	cov_f_c: cover property ($rose(fault_o));
	cov_full_c: cover property (fault_o && ss_level_o == SS_FULL);
endmodule : apf_chk
bind apf_core apf_chk #(.BLANK_CYC(BLANK_CYC), .SS_FULL(SS_FULL), .SS_STEP(SS_STEP)) u_chk (.*);

// ---- apf_stage.sv ----
`timescale 1ns/1ps
module apf_stage (
	// clock
	input wire logic clk_i,
	// gate drives
	input wire logic out_a_i,
	input wire logic out_b_i,
	// thresholds and fault command
	input wire logic [7:0] pwm_at_i,
	input wire logic [7:0] lim_at_i,
	input wire logic ovc_i,
	// comparator flags
	output logic pwm_cmp_o,
	output logic lim_o,
	output logic ovc_o
);
	// ====
	// sense ramp grows only while a gate conducts
	logic [7:0] on_r = 8'h00;
	always_ff @(posedge clk_i) begin
		on_r <= (out_a_i | out_b_i) ? on_r + 8'h01 : 8'h00;
	end
	assign pwm_cmp_o = on_r >= pwm_at_i;
	assign lim_o = on_r >= lim_at_i;
	assign ovc_o = ovc_i;
	// no sync pulse is ever injected, so the oscillator runs free at its programmed rate
endmodule : apf_stage

// ---- alternating_pwm_fault_control_test.sv ----
`timescale 1ns/1ps
module alternating_pwm_fault_control_test;
	import apf_pkg::*;
	// ====
	// bench
	localparam int unsigned BLK = 20;
	localparam int unsigned SSF = 200;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [1:0] sup = 2'b00;
	logic ovc_i = 1'b0;
	logic [7:0] pwm_at = 8'hFF;
	logic [7:0] lim_at = 8'hFF;
	logic pwm, lim, ovc, out_a_o, out_b_o, clk_pin, ea_hold, fault_o, lockout;
	logic [15:0] ss;
	int failures = 0;
	int checks_done = 0;
	int n, w;
	apf_core #(.OSC_PERIOD(100), .OSC_DISCH(10), .BLANK_CYC(BLK), .SS_FULL(SSF), .SS_STEP(1)) uut (
		.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1), .pwm_cmp_i(pwm), .current_sense_input_lim_i(lim),
		.current_sense_input_ovc_i(ovc), .vcc_ok_i(sup[1]), .vref_ok_i(sup[0]), .out_a_o(out_a_o),
		.out_b_o(out_b_o), .clock_out_blank_pin_o(clk_pin), .ss_level_o(ss), .ea_hold_low_o(ea_hold),
		.fault_o(fault_o), .undervoltage_lockout_o(lockout), .blanking_o());
	apf_stage u_stage (.clk_i(clk_i), .out_a_i(out_a_o), .out_b_i(out_b_o), .pwm_at_i(pwm_at),
		.lim_at_i(lim_at), .ovc_i(ovc_i), .pwm_cmp_o(pwm), .lim_o(lim), .ovc_o(ovc));
	initial begin
		forever #10 clk_i = ~clk_i;
	end
	function automatic logic sel(input int b);
		return b == 0 ? out_a_o : b == 1 ? out_b_o : out_a_o | out_b_o;
	endfunction : sel
	// wide enough for the packed status words of the lockout check
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// skips a running pulse, then counts low samples until the next one
	task wait_out(input int b, output int c);
		c = 0;
		while (sel(b) === 1'b1 && c < 300) begin
			@(negedge clk_i);
			c++;
		end
		c = 0;
		while (sel(b) !== 1'b1 && c < 300) begin
			@(negedge clk_i);
			c++;
		end
	endtask : wait_out
	task width(input int b, output int c);
		c = 0;
		while (sel(b) === 1'b1 && c < 300) begin
			@(negedge clk_i);
			c++;
		end
	endtask : width
	task t_alt;
		int f;
		@(posedge clk_i) pwm_at <= 8'h28;
		wait_out(2, n);
		f = out_b_o;
		width(f, w);
		chk(w >= 40 && w <= 46, 1);
		wait_out(1 - f, n);
		chk(w + n, 100);
	endtask : t_alt
	task t_blank;
		for (int k = 0; k < 2; k++) begin
			@(posedge clk_i);
			pwm_at <= k ? 8'hFF : 8'h01;
			lim_at <= k ? 8'h01 : 8'hFF;
			wait_out(2, n);
			width(2, w);
			chk(w >= BLK && w <= BLK + 5, 1);
		end
	endtask : t_blank
	task t_lockout;
		for (int k = 0; k < 2; k++) begin
			@(posedge clk_i) sup <= k ? 2'b01 : 2'b10;
			repeat (5) @(negedge clk_i);
			chk({out_a_o, out_b_o, lockout, ss}, 19'h10000);
			@(posedge clk_i) sup <= 2'b11;
			repeat (5) @(negedge clk_i);
			chk(lockout, 0);
		end
	endtask : t_lockout
	// overcurrent lands while soft-start is still charging
	task t_ovc;
		logic [15:0] mx;
		@(posedge clk_i);
		pwm_at <= 8'hC8;
		lim_at <= 8'hFF;
		wait_out(2, n);
		@(posedge clk_i) ovc_i <= 1'b1;
		n = 0;
		while (sel(2) === 1'b1 && n < 10) begin
			@(negedge clk_i);
			n++;
		end
		chk(n <= 5, 1);
		chk(fault_o, 1);
		repeat (20) @(negedge clk_i);
		@(posedge clk_i) ovc_i <= 1'b0;
		@(negedge clk_i);
		mx = ss;
		n = 0;
		while (fault_o === 1'b1 && n < 900) begin
			@(negedge clk_i);
			n++;
			if (ss > mx) mx = ss;
		end
		chk(fault_o, 0);
		chk(mx, SSF);
		// the latch drops on the edge that empties soft-start
		chk(ss, 0);
	endtask : t_ovc
	task print_verdict;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (20000) @(posedge clk_i);
		failures++;
		print_verdict();
	end
	initial begin
		repeat (10) @(posedge clk_i);
		srst_i <= 1'b0;
		@(negedge clk_i);
		chk({out_a_o, out_b_o, fault_o, ea_hold, clk_pin, lockout}, 6'h07);
		@(posedge clk_i) sup <= 2'b11;
		t_alt();
		t_blank();
		t_lockout();
		t_ovc();
		print_verdict();
	end
endmodule : alternating_pwm_fault_control_test
